/* File: hw/sbsm_port.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - break frame: start, twelve zeros, stop
// - break request plus enable and a buffer write sends break frame
// - break ignores buffer data, shifts zeros
// - break request clears after break stop bit
// - buffer accepts next byte during break
// - shifter empty tracks break frames too
// - wake watches two transitions, then data
// - clock source bit makes us clock master
// - clocked mode is half duplex
// - mode bit clocked, port bit claims pins
// - polarity bit sets shift clock idle level
// - shifter loads only after last bit sent
// - one-cycle load, then buffer empty flag
// - empty flag ignores enable, cleared by write
// - shifter empty read-only, polled, no request
// - master receive samples on falling clock
// - single one word, continuous wins over single
// - receive flag set, request only if enabled
// - clearing continuous receive clears errors
module sbsm_port #(
   parameter int DIV_WIDTH = 16
) (
   input  wire logic        pclk,               // system clock
   input  wire logic        presetn,            // async reset, active low
   input  wire logic        psel,               // apb select
   input  wire logic        penable,            // apb access phase
   input  wire logic        pwrite,             // apb direction
   input  wire logic [11:0] paddr,              // apb byte address
   input  wire logic [31:0] pwdata,             // apb write data
   output logic      [31:0] prdata,             // apb read data
   output logic             pready,             // apb ready
   output logic             pslverr,            // apb error, unmapped
   output logic             shift_clock_pin_out, // clock / serial out level
   output logic             shift_clock_pin_oe, // clock pin drive enable
   input  wire logic        shift_data_pin_in,  // data pin level
   output logic             shift_data_pin_out, // data pin drive level
   output logic             shift_data_pin_oe,  // data pin drive enable
   output logic             tx_irq_request,     // buffer empty and enabled
   output logic             rx_irq_request      // word received and enabled
);

   if (DIV_WIDTH != 16) begin : g_bad_width
      $error("divisor is built from two bytes, DIV_WIDTH must be 16");
   end

   sbsm_baud_if #(.DIV_WIDTH(DIV_WIDTH)) bif ();

   sbsm_baud_gen #(.DIV_WIDTH(DIV_WIDTH)) u_baud (
      .pclk    (pclk),
      .presetn (presetn),
      .bif     (bif)
   );

   // software visible state
   logic [7:0]  tx_ctl;
   logic [7:0]  rx_ctl;
   logic [7:0]  baud_ctl;
   logic [7:0]  enables;
   logic [7:0]  div_high;
   logic [7:0]  div_low;
   logic [7:0]  tx_buf;
   logic        tx_full;
   logic [7:0]  rx_buf;
   logic        rx_done;

   // shifting engine
   sbsm_pkg::sbsm_state_e state;
   logic [14:0] sh;
   logic [3:0]  bits_left;
   logic [3:0]  rx_total;
   logic [10:0] rframe;
   logic        ph;
   logic        is_break;
   logic        ck_level;
   logic        dt_meta;
   logic        dt_sync;
   logic        dt_prev;

   // one-cycle events from the engine to the register blocks
   logic        ev_store;
   logic [8:0]  ev_word;
   logic        ev_ferr;
   logic        ev_break_done;
   logic        ev_single_done;
   logic        ev_wake;

   logic [7:0]  idx;
   logic        addr_ok;
   logic        wr;
   logic        rd_access;
   logic [7:0]  rd_val;
   logic        load;
   logic        sync_mode;
   logic        master;
   logic        port_on;
   logic        rx_want;
   logic        sample_now;
   logic [10:0] rnext;
   logic [10:0] aligned;
   logic        dt_fall;
   logic        dt_rise;

   assign idx       = paddr[9:2];
   assign addr_ok   = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 && sbsm_pkg::sbsm_index_ok(idx);
   assign wr        = psel && penable && pwrite && addr_ok;
   assign rd_access = psel && penable && !pwrite && addr_ok;
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !addr_ok;

   assign sync_mode = tx_ctl[sbsm_pkg::TX_SYNC];
   assign master    = tx_ctl[sbsm_pkg::TX_CLK_MASTER];
   assign port_on   = rx_ctl[sbsm_pkg::RC_PORT_EN];
   // continuous wins by the or; single is masked while its hardware clear is still on its way
   assign rx_want   = (rx_ctl[sbsm_pkg::RC_SINGLE] && !ev_single_done) || rx_ctl[sbsm_pkg::RC_CONT];
   assign dt_fall   = dt_prev && !dt_sync;
   assign dt_rise   = !dt_prev && dt_sync;

   // a waiting word goes to the shifter only when the shifter is idle
   assign load = state == sbsm_sync_idle() && tx_full && tx_ctl[sbsm_pkg::TX_ENABLE] && port_on
                 && (!sync_mode || master);

   function automatic sbsm_pkg::sbsm_state_e sbsm_sync_idle();
      return sbsm_pkg::ST_IDLE;
   endfunction : sbsm_sync_idle

   // falling edge of the shift clock: active-to-idle when idle is low, idle-to-active otherwise
   assign sample_now = bif.tick && (state == sbsm_pkg::ST_SRX ? (ph != baud_ctl[sbsm_pkg::BC_CLK_POL])
                                                              : (state == sbsm_pkg::ST_ARX && !ph));
   assign rnext   = sample_now ? {dt_sync, rframe[10:1]} : rframe;
   assign aligned = rnext >> (sbsm_pkg::RX_FRAME_W - rx_total + {3'h0, !sync_mode});

   assign bif.divisor = baud_ctl[sbsm_pkg::BC_WIDE_DIV] ? {div_high, div_low} : {8'h00, div_low};
   assign bif.restart = load || (state == sbsm_pkg::ST_IDLE && !sync_mode && port_on && dt_fall);

   // data pin passes two flops before any logic looks at it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dt_meta <= 1'b1;
         dt_sync <= 1'b1;
         dt_prev <= 1'b1;
      end else begin
         dt_meta <= shift_data_pin_in;
         dt_sync <= dt_meta;
         dt_prev <= dt_sync;
      end
   end

   // shifting engine: one bit takes two baud ticks in every mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state          <= sbsm_pkg::ST_IDLE;
         sh             <= '1;
         bits_left      <= '0;
         rx_total       <= '0;
         rframe         <= '0;
         ph             <= 1'b0;
         is_break       <= 1'b0;
         ck_level       <= 1'b0;
         ev_store       <= 1'b0;
         ev_word        <= '0;
         ev_ferr        <= 1'b0;
         ev_break_done  <= 1'b0;
         ev_single_done <= 1'b0;
         ev_wake        <= 1'b0;
      end else begin
         ev_store       <= 1'b0;
         ev_ferr        <= 1'b0;
         ev_break_done  <= 1'b0;
         ev_single_done <= 1'b0;
         ev_wake        <= 1'b0;
         rframe         <= rnext;
         case (state)
            sbsm_pkg::ST_IDLE: begin
               ph       <= 1'b0;
               ck_level <= baud_ctl[sbsm_pkg::BC_CLK_POL];
               if (load) begin
                  state <= sbsm_pkg::ST_TX;
                  if (!sync_mode && tx_ctl[sbsm_pkg::TX_BREAK] && !ev_break_done) begin
                     is_break  <= 1'b1;
                     sh        <= 15'h2000;                  // zeros, stop at the end
                     bits_left <= sbsm_pkg::BREAK_BITS;
                  end else if (!sync_mode) begin
                     is_break  <= 1'b0;
                     sh        <= {5'h1F, tx_ctl[sbsm_pkg::TX_NINE] ? tx_ctl[sbsm_pkg::TX_NINTH] : 1'b1,
                                   tx_buf, 1'b0};
                     bits_left <= sbsm_pkg::ASYNC_BITS + {3'h0, tx_ctl[sbsm_pkg::TX_NINE]};
                  end else begin
                     is_break  <= 1'b0;
                     sh        <= {6'h3F, tx_ctl[sbsm_pkg::TX_NINTH], tx_buf};
                     bits_left <= sbsm_pkg::DATA_BITS + {3'h0, tx_ctl[sbsm_pkg::TX_NINE]};
                  end
               end else if (sync_mode && master && port_on && rx_want) begin
                  state     <= sbsm_pkg::ST_SRX;
                  rx_total  <= sbsm_pkg::DATA_BITS + {3'h0, rx_ctl[sbsm_pkg::RC_NINE]};
                  bits_left <= sbsm_pkg::DATA_BITS + {3'h0, rx_ctl[sbsm_pkg::RC_NINE]};
               end else if (!sync_mode && port_on && dt_fall) begin
                  if (baud_ctl[sbsm_pkg::BC_WAKE]) begin
                     state <= sbsm_pkg::ST_WAKE;
                  end else if (rx_ctl[sbsm_pkg::RC_CONT]) begin
                     state     <= sbsm_pkg::ST_ARX;
                     rx_total  <= sbsm_pkg::ASYNC_BITS + {3'h0, rx_ctl[sbsm_pkg::RC_NINE]};
                     bits_left <= sbsm_pkg::ASYNC_BITS + {3'h0, rx_ctl[sbsm_pkg::RC_NINE]};
                  end
               end
            end
            sbsm_pkg::ST_TX: begin
               if (bif.tick) begin
                  ph <= !ph;
                  if (!ph) begin
                     ck_level <= !baud_ctl[sbsm_pkg::BC_CLK_POL];
                  end else begin
                     ck_level  <= baud_ctl[sbsm_pkg::BC_CLK_POL];
                     sh        <= {1'b1, sh[14:1]};
                     bits_left <= bits_left - 4'h1;
                     if (bits_left == 4'h1) begin
                        state         <= sbsm_pkg::ST_IDLE;
                        ev_break_done <= is_break;
                     end
                  end
               end
            end
            sbsm_pkg::ST_SRX: begin
               if (bif.tick) begin
                  ph       <= !ph;
                  ck_level <= ph ? baud_ctl[sbsm_pkg::BC_CLK_POL] : !baud_ctl[sbsm_pkg::BC_CLK_POL];
                  if (ph) begin
                     bits_left <= bits_left - 4'h1;
                     if (bits_left == 4'h1) begin
                        ev_store <= 1'b1;
                        ev_word  <= aligned[8:0];
                        // continuous keeps clocking unless a word waits to go out
                        if (rx_ctl[sbsm_pkg::RC_CONT] && !(tx_full && tx_ctl[sbsm_pkg::TX_ENABLE])) begin
                           bits_left <= rx_total;
                        end else begin
                           state          <= sbsm_pkg::ST_IDLE;
                           ev_single_done <= !rx_ctl[sbsm_pkg::RC_CONT];
                        end
                     end
                  end
               end
            end
            sbsm_pkg::ST_ARX: begin
               if (bif.tick) begin
                  ph <= !ph;
                  if (!ph) begin
                     bits_left <= bits_left - 4'h1;
                     if (bits_left == rx_total && dt_sync) begin
                        state <= sbsm_pkg::ST_IDLE;          // glitch, not a start bit
                     end else if (bits_left == 4'h1) begin
                        state    <= sbsm_pkg::ST_IDLE;
                        ev_store <= 1'b1;
                        ev_word  <= aligned[8:0];
                        ev_ferr  <= !dt_sync;
                     end
                  end
               end
            end
            sbsm_pkg::ST_WAKE: begin
               if (dt_rise) begin
                  state   <= sbsm_pkg::ST_IDLE;
                  ev_wake <= 1'b1;
               end
            end
            default: begin
               state <= sbsm_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // transmit buffer: a write while the shifter loads refills it at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_buf  <= sbsm_pkg::REG_RESET;
         tx_full <= 1'b0;
      end else if (wr && idx == sbsm_pkg::IDX_TX_BUF) begin
         tx_buf  <= pwdata[7:0];
         tx_full <= 1'b1;
      end else if (load) begin
         tx_full <= 1'b0;
      end
   end

   // transmit control; a software write in the same cycle beats the hardware clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_ctl <= sbsm_pkg::TX_CTL_RESET;
      end else begin
         if (wr && idx == sbsm_pkg::IDX_TX_CTL) begin
            tx_ctl <= pwdata[7:0] & sbsm_pkg::TX_CTL_WMASK;
         end else if (ev_break_done) begin
            tx_ctl[sbsm_pkg::TX_BREAK] <= 1'b0;
         end
      end
   end

   // receive control and status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_ctl <= sbsm_pkg::REG_RESET;
      end else begin
         if (wr && idx == sbsm_pkg::IDX_RX_CTL) begin
            rx_ctl[7:3] <= pwdata[7:3];
            if (!pwdata[sbsm_pkg::RC_CONT]) begin
               rx_ctl[sbsm_pkg::RC_FRAME_ERR] <= 1'b0;
               rx_ctl[sbsm_pkg::RC_OVERRUN]   <= 1'b0;
            end
         end else if (ev_single_done) begin
            rx_ctl[sbsm_pkg::RC_SINGLE] <= 1'b0;
         end
         if (ev_store && rx_done && !(rd_access && idx == sbsm_pkg::IDX_RX_BUF)) begin
            rx_ctl[sbsm_pkg::RC_OVERRUN] <= 1'b1;    // unread word kept, new one dropped
         end else if (ev_store) begin
            rx_ctl[sbsm_pkg::RC_NINTH]     <= ev_word[8];
            rx_ctl[sbsm_pkg::RC_FRAME_ERR] <= ev_ferr;
         end
      end
   end

   // receive buffer and its flag; a new word beats a read in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_buf  <= sbsm_pkg::REG_RESET;
         rx_done <= 1'b0;
      end else if (ev_wake || (ev_store && (!rx_done || (rd_access && idx == sbsm_pkg::IDX_RX_BUF)))) begin
         rx_done <= 1'b1;
         if (ev_store) begin
            rx_buf <= ev_word[7:0];
         end
      end else if (rd_access && idx == sbsm_pkg::IDX_RX_BUF) begin
         rx_done <= 1'b0;
      end
   end

   // baud control, enables and divisor
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_ctl <= sbsm_pkg::REG_RESET;
         enables  <= sbsm_pkg::REG_RESET;
         div_high <= sbsm_pkg::REG_RESET;
         div_low  <= sbsm_pkg::REG_RESET;
      end else begin
         if (wr && idx == sbsm_pkg::IDX_BAUD_CTL) begin
            baud_ctl <= pwdata[7:0] & sbsm_pkg::BAUD_WMASK;
         end else if (ev_wake) begin
            baud_ctl[sbsm_pkg::BC_WAKE] <= 1'b0;
         end
         if (wr && idx == sbsm_pkg::IDX_ENABLES) begin
            enables <= pwdata[7:0];
         end
         if (wr && idx == sbsm_pkg::IDX_DIV_HIGH) begin
            div_high <= pwdata[7:0];
         end
         if (wr && idx == sbsm_pkg::IDX_DIV_LOW) begin
            div_low <= pwdata[7:0];
         end
      end
   end

   always_comb begin
      rd_val = 8'h00;
      case (idx)
         sbsm_pkg::IDX_FLAGS: begin
            rd_val[sbsm_pkg::FLG_RX_DONE]  = rx_done;
            rd_val[sbsm_pkg::FLG_TX_EMPTY] = !tx_full;
         end
         sbsm_pkg::IDX_BAUD_CTL: begin
            rd_val = baud_ctl;
            rd_val[sbsm_pkg::BC_RX_IDLE] = state != sbsm_pkg::ST_ARX;
         end
         sbsm_pkg::IDX_DIV_HIGH: rd_val = div_high;
         sbsm_pkg::IDX_DIV_LOW:  rd_val = div_low;
         sbsm_pkg::IDX_RX_BUF:   rd_val = rx_buf;
         sbsm_pkg::IDX_TX_BUF:   rd_val = tx_buf;
         sbsm_pkg::IDX_TX_CTL: begin
            rd_val = tx_ctl;
            rd_val[sbsm_pkg::TX_SHIFT_EMPTY] = state != sbsm_pkg::ST_TX;
         end
         sbsm_pkg::IDX_RX_CTL:   rd_val = rx_ctl;
         sbsm_pkg::IDX_ENABLES:  rd_val = enables;
         default:                rd_val = 8'h00;
      endcase
   end

   // read data is captured in the setup phase so it stands through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h000000, rd_val};
      end
   end

   // pins; the flag alone never drives the request, its enable gates it
   always_comb begin
      shift_clock_pin_oe  = port_on && (sync_mode ? master : tx_ctl[sbsm_pkg::TX_ENABLE]);
      shift_clock_pin_out = sync_mode ? ck_level : (state == sbsm_pkg::ST_TX ? sh[0] : 1'b1);
      shift_data_pin_oe   = port_on && sync_mode && master && state == sbsm_pkg::ST_TX;
      shift_data_pin_out  = sh[0];
      tx_irq_request      = !tx_full && enables[sbsm_pkg::FLG_TX_EMPTY];
      rx_irq_request      = rx_done && enables[sbsm_pkg::FLG_RX_DONE];
   end

endmodule : sbsm_port

/* File: pkg/sbsm_pkg.sv */
package sbsm_pkg;

   // register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_FLAGS      = 8'h0C;
   localparam logic [7:0] IDX_BAUD_CTL   = 8'h11;
   localparam logic [7:0] IDX_DIV_HIGH   = 8'h12;
   localparam logic [7:0] IDX_DIV_LOW    = 8'h13;
   localparam logic [7:0] IDX_RX_BUF     = 8'h14;
   localparam logic [7:0] IDX_TX_BUF     = 8'h15;
   localparam logic [7:0] IDX_TX_CTL     = 8'h16;
   localparam logic [7:0] IDX_RX_CTL     = 8'h17;
   localparam logic [7:0] IDX_ENABLES    = 8'h8C;

   // peripheral_flags_one / peripheral_enables_one
   localparam int FLG_RX_DONE    = 5;
   localparam int FLG_TX_EMPTY   = 4;
   // baud_control
   localparam int BC_RX_IDLE     = 6;
   localparam int BC_CLK_POL     = 5;
   localparam int BC_WIDE_DIV    = 3;
   localparam int BC_WAKE        = 1;
   // transmit_control_status
   localparam int TX_CLK_MASTER  = 7;
   localparam int TX_NINE        = 6;
   localparam int TX_ENABLE      = 5;
   localparam int TX_SYNC        = 4;
   localparam int TX_BREAK       = 3;
   localparam int TX_SHIFT_EMPTY = 1;
   localparam int TX_NINTH       = 0;
   // receive_control_status
   localparam int RC_PORT_EN     = 7;
   localparam int RC_NINE        = 6;
   localparam int RC_SINGLE      = 5;
   localparam int RC_CONT        = 4;
   localparam int RC_FRAME_ERR   = 2;
   localparam int RC_OVERRUN     = 1;
   localparam int RC_NINTH       = 0;

   localparam logic [7:0] TX_CTL_RESET  = 8'h02;
   localparam logic [7:0] REG_RESET     = 8'h00;
   // writable bit masks of the mixed registers
   localparam logic [7:0] TX_CTL_WMASK  = 8'hFD;
   localparam logic [7:0] RX_CTL_WMASK  = 8'hF8;
   localparam logic [7:0] BAUD_WMASK    = 8'h2A;

   // frame shapes, counted in bits
   localparam logic [3:0] DATA_BITS     = 4'h8;
   localparam logic [3:0] BREAK_BITS    = 4'hE;  // start, 12 zeros, stop
   localparam logic [3:0] ASYNC_BITS    = 4'hA;  // start, 8 data, stop
   localparam logic [3:0] RX_FRAME_W    = 4'hB;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_TX   = 3'b001,
      ST_SRX  = 3'b010,
      ST_ARX  = 3'b011,
      ST_WAKE = 3'b100
   } sbsm_state_e;

   function automatic logic sbsm_index_ok(input logic [7:0] idx);
      return idx == IDX_FLAGS || (idx >= IDX_BAUD_CTL && idx <= IDX_RX_CTL) || idx == IDX_ENABLES;
   endfunction : sbsm_index_ok

endpackage : sbsm_pkg

/* File: pkg/sbsm_baud_if.sv */
`timescale 1ns/1ps
interface sbsm_baud_if #(parameter int DIV_WIDTH = 16);
   logic [DIV_WIDTH-1:0] divisor;
   logic                 restart;
   logic                 tick;
   modport gen  (input divisor, input restart, output tick);
   modport user (output divisor, output restart, input tick);
endinterface : sbsm_baud_if

/* File: hw/sbsm_baud_gen.sv */
`timescale 1ns/1ps
module sbsm_baud_gen #(
   parameter int DIV_WIDTH = 16
) (
   input wire logic pclk,        // system clock
   input wire logic presetn,     // async reset, active low
   sbsm_baud_if.gen bif          // divisor in, tick out
);

   logic [DIV_WIDTH-1:0] count;

   // restart realigns the tick grid to a shifter load or a falling edge seen on the line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
      end else if (bif.restart || count == bif.divisor) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

   // combinational, so the first bit after a restart is no longer than the rest
   assign bif.tick = !bif.restart && count == bif.divisor;

endmodule : sbsm_baud_gen

/* File: testbench/sbsm_sva.sv */
`timescale 1ns/1ps
module sbsm_sva (
   input wire logic        pclk,                // clock
   input wire logic        presetn,             // reset
   input wire logic        psel,                // apb
   input wire logic        penable,             // apb
   input wire logic        pwrite,              // apb
   input wire logic [11:0] paddr,               // apb
   input wire logic [31:0] pwdata,              // apb
   input wire logic [31:0] prdata,              // apb
   input wire logic        pready,              // apb
   input wire logic        pslverr,             // apb
   input wire logic        shift_clock_pin_out, // pin
   input wire logic        shift_clock_pin_oe,  // pin
   input wire logic        shift_data_pin_in,   // pin
   input wire logic        shift_data_pin_out,  // pin
   input wire logic        shift_data_pin_oe,   // pin
   input wire logic        tx_irq_request,      // irq
   input wire logic        rx_irq_request       // irq
);
   logic tc_m, tc_s, pen, pol, en_t, en_r;
   wire [7:0] idx = paddr[9:2];
   wire ok = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0 && (idx == 8'h0C || (idx >= 8'h11 && idx <= 8'h17) || idx == 8'h8C);
   // shadow of the control bits that software alone changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) {tc_m, tc_s, pen, pol, en_t, en_r} <= 6'h00;
      else if (psel && penable && pwrite && ok) begin
         if (paddr == 12'h058) {tc_m, tc_s} <= {pwdata[7], pwdata[4]};
         if (paddr == 12'h05C) pen <= pwdata[7];
         if (paddr == 12'h044) pol <= pwdata[5];
         if (paddr == 12'h230) {en_r, en_t} <= pwdata[5:4];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_acc; psel && penable; endsequence
   a_zero_wait: assert property (s_setup |=> pready) else $error("no ready after setup");
   a_slverr_map: assert property (s_acc |-> pslverr == !ok) else $error("error flag wrong for address");
   a_read_upper: assert property (s_acc |-> prdata[31:8] == 24'h000000) else $error("upper read lanes set");
   a_rx_irq_gate: assert property (!en_r |-> !rx_irq_request) else $error("rx request while disabled");
   a_tx_irq_gate: assert property (!en_t |-> !tx_irq_request) else $error("tx request while disabled");
   a_pins_free: assert property (!pen |-> !shift_clock_pin_oe && !shift_data_pin_oe) else $error("pins driven");
   a_slave_no_clk: assert property (tc_s && !tc_m |-> !shift_clock_pin_oe) else $error("slave drives clock");
   a_data_master: assert property (shift_data_pin_oe |-> tc_s && tc_m && pen) else $error("data driven");
   a_idle_start: assert property ($rose(shift_data_pin_oe) |-> shift_clock_pin_out == pol) else $error("not idle");
   a_data_on_idle: assert property (shift_data_pin_oe && $past(shift_data_pin_oe) && $changed(shift_data_pin_out)
      |-> shift_clock_pin_out == pol) else $error("data moved mid bit");
endmodule : sbsm_sva
bind sbsm_port sbsm_sva chk_u (.*);

/* File: testbench/sbsm_peer.sv */
`timescale 1ns/1ps
module sbsm_peer (
   input  wire logic        clk_line,  // shift clock, idle high
   input  wire logic        arm,       // low restarts the word
   input  wire logic        dev_oe,    // device drives data
   input  wire logic        data_line, // resolved data level
   input  wire logic [7:0]  tx_word,   // word sent to the device
   output logic             data_out,  // level driven by peer
   output logic      [15:0] rx_word    // bits taken from the device
);
   logic [2:0] idx = 3'h0;
   // bit changes as the clock returns idle, so it stands over the falling sample edge
   assign data_out = tx_word[idx];
   always @(posedge clk_line or negedge arm)
      if (!arm) idx <= 3'h0;
      else if (!dev_oe) idx <= idx + 3'h1;
   always @(negedge clk_line)
      if (dev_oe) rx_word <= {data_line, rx_word[15:1]};
endmodule : sbsm_peer

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, arm = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, ck_out, ck_oe, dt_out, dt_oe, tx_irq, rx_irq, peer_dt, err;
   logic [7:0]  rd;
   logic [15:0] peer_rx;
   int          n_errors = 0, compares = 0, cyc = 0, lo = 0, last = 0, runs = 0;
   wire         dt_line = dt_oe ? dt_out : peer_dt;
   sbsm_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .shift_clock_pin_out(ck_out), .shift_clock_pin_oe(ck_oe), .shift_data_pin_in(dt_line),
      .shift_data_pin_out(dt_out), .shift_data_pin_oe(dt_oe), .tx_irq_request(tx_irq), .rx_irq_request(rx_irq));
   sbsm_peer peer_u (.clk_line(ck_out), .arm(arm), .dev_oe(dt_oe), .data_line(dt_line), .tx_word(8'h96),
      .data_out(peer_dt), .rx_word(peer_rx));
   initial forever #2 pclk = ~pclk;
   // lengths of low runs on the serial line
   always @(posedge pclk)
      if (!ck_out) lo <= lo + 1;
      else if (lo != 0) begin
         last <= lo;
         runs <= runs + 1;
         lo <= 0;
      end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk(rd & m, exp);
   endtask : rd_chk
   task automatic wait_set(input logic [11:0] a, input logic [7:0] m);
      int i;
      i = 0;
      do begin apb(1'b0, a, 8'h00); i++; end while ((rd & m) !== m && i < 300);
      chk(rd & m, m);
   endtask : wait_set
   task automatic wait_run(input int n, input logic [15:0] exp);
      int i;
      for (i = 0; i < 600 && runs < n; i++) @(posedge pclk);
      chk(last[15:0], exp);
   endtask : wait_run
   task automatic t_regs;
      rd_chk(12'h058, 8'hFF, 8'h02);
      rd_chk(12'h05C, 8'hFF, 8'h00);
      rd_chk(12'h044, 8'hFF, 8'h40);
      apb(1'b1, 12'h040, 8'h5A);
      chk({7'h00, err}, 8'h01);
      apb(1'b1, 12'h058, 8'h10);
      rd_chk(12'h058, 8'hFF, 8'h12);
   endtask : t_regs
   task automatic t_sync_tx;
      apb(1'b1, 12'h04C, 8'h09);
      apb(1'b1, 12'h044, 8'h20);
      apb(1'b1, 12'h05C, 8'h80);
      apb(1'b1, 12'h058, 8'hB0);
      apb(1'b1, 12'h054, 8'hA5);
      rd_chk(12'h030, 8'h10, 8'h10);
      rd_chk(12'h058, 8'h02, 8'h00);
      apb(1'b1, 12'h054, 8'h3C);
      rd_chk(12'h030, 8'h10, 8'h00);
      wait_set(12'h030, 8'h10);
      wait_set(12'h058, 8'h02);
      chk(peer_rx, 16'h3CA5);
   endtask : t_sync_tx
   task automatic t_sync_rx;
      arm <= 1'b0;
      apb(1'b1, 12'h230, 8'h20);
      chk({7'h00, tx_irq}, 8'h00);
      apb(1'b1, 12'h230, 8'h30);
      chk({7'h00, tx_irq}, 8'h01);
      arm <= 1'b1;
      apb(1'b1, 12'h05C, 8'hA0);
      wait_set(12'h030, 8'h20);
      chk({7'h00, rx_irq}, 8'h01);
      rd_chk(12'h05C, 8'h20, 8'h00);
      rd_chk(12'h050, 8'hFF, 8'h96);
      chk({7'h00, rx_irq}, 8'h00);
   endtask : t_sync_rx
   task automatic t_break;
      int base;
      apb(1'b1, 12'h058, 8'h28);
      base = runs;
      apb(1'b1, 12'h054, 8'hFF);
      apb(1'b1, 12'h054, 8'h55);
      rd_chk(12'h058, 8'h0A, 8'h08);
      wait_run(base + 1, 16'h0104);
      wait_run(base + 2, 16'h0014);
      rd_chk(12'h058, 8'h08, 8'h00);
      apb(1'b1, 12'h058, 8'h60);
      apb(1'b1, 12'h054, 8'h7F);
      wait_run(base + 8, 16'h0028);
   endtask : t_break
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_sync_tx();
      t_sync_rx();
      t_break();
      finish_test();
   end
endmodule : testbench
